// file: mc_code_pkg.sv
package mc_code_pkg;

  // ----------------------------------------------------------------
  // status entry layout
  // ----------------------------------------------------------------
  localparam int MSC_LSB = 16;
  localparam int MSC_MSB = 31;
  localparam int UNCORR_BIT = 61;
  localparam int OVER_BIT = 62;
  localparam int VAL_BIT = 63;

  // architectural type codes held in bits 15:0 of the entry
  localparam logic [15:0] TYPE_A_ERR_CODE = 16'h010b;
  localparam logic [15:0] TYPE_B_ERR_CODE = 16'h0e0f;
  localparam logic [15:0] TYPE_C_ERR_CODE = 16'h0400;

  // ----------------------------------------------------------------
  // type A (last-level cache) sub-codes
  // ----------------------------------------------------------------
  localparam int LLC_WAYS = 8;
  localparam logic [2:0] LLC_NO_ERROR = 3'h0;
  localparam logic [2:0] LLC_MULTI_CORR = 3'h1;
  localparam logic [2:0] LLC_MULTI_UNCORR = 3'h2;
  localparam logic [2:0] LLC_MULTI_HIT = 3'h3;
  localparam logic [2:0] LLC_NO_ERROR_ALT = 3'h4;
  localparam logic [2:0] LLC_ONE_CORR = 3'h5;
  localparam logic [2:0] LLC_ONE_UNCORR = 3'h6;
  localparam logic [2:0] LLC_MIXED = 3'h7;
  localparam logic [1:0] LLC_RESERVED_BITS = 2'h0;
  localparam logic [10:0] LLC_FIXED_PATTERN = 11'h100;

  // ----------------------------------------------------------------
  // type B (system bus) events, index order is also priority order
  // ----------------------------------------------------------------
  localparam int BUS_EVENTS = 11;
  localparam int BUS_ECC_INDEX = 8;

  function automatic logic [3:0] bus_bit_pos(input int idx);
    case (idx)
      0: bus_bit_pos = 4'h0;
      1: bus_bit_pos = 4'h1;
      2: bus_bit_pos = 4'h2;
      3: bus_bit_pos = 4'h4;
      4: bus_bit_pos = 4'h5;
      5: bus_bit_pos = 4'h6;
      6: bus_bit_pos = 4'h7;
      7: bus_bit_pos = 4'h8;
      8: bus_bit_pos = 4'h9;
      9: bus_bit_pos = 4'ha;
      default: bus_bit_pos = 4'hb;
    endcase
  endfunction : bus_bit_pos

  localparam logic [15:0] BUS_DEFINED_MASK = 16'h0ff7;

  // ----------------------------------------------------------------
  // type C (cache bus controller) events
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CBUS_INCL_CORE0, CBUS_INCL_CORE1, CBUS_WREX_CORE0, CBUS_WREX_CORE1,
    CBUS_INCL_BUS, CBUS_SNOOP_STALL, CBUS_WRITE_STALL, CBUS_ARB_TIMEOUT,
    CBUS_OOO_QUEUE, CBUS_THERMAL, CBUS_TIMEOUT_A, CBUS_TIMEOUT_B,
    CBUS_QUEUE_FULL, CBUS_CECC_BUS, CBUS_CECC_CORE0, CBUS_CECC_CORE1,
    CBUS_UECC_BUS, CBUS_UECC_CORE0, CBUS_UECC_CORE1, CBUS_UNUSED
  } cbus_kind_type;

  localparam logic [3:0] CBUS_CORR_NIBBLE = 4'hc;

  function automatic logic [15:0] cbus_code(input cbus_kind_type kind);
    case (kind)
      CBUS_INCL_CORE0: cbus_code = 16'h0001;
      CBUS_INCL_CORE1: cbus_code = 16'h0002;
      CBUS_WREX_CORE0: cbus_code = 16'h0003;
      CBUS_WREX_CORE1: cbus_code = 16'h0004;
      CBUS_INCL_BUS: cbus_code = 16'h0005;
      CBUS_SNOOP_STALL: cbus_code = 16'h0006;
      CBUS_WRITE_STALL: cbus_code = 16'h0007;
      CBUS_ARB_TIMEOUT: cbus_code = 16'h0008;
      CBUS_OOO_QUEUE: cbus_code = 16'h0009;
      CBUS_THERMAL: cbus_code = 16'h0100;
      CBUS_TIMEOUT_A: cbus_code = 16'h0200;
      CBUS_TIMEOUT_B: cbus_code = 16'h0300;
      CBUS_QUEUE_FULL: cbus_code = 16'h0400;
      CBUS_CECC_BUS: cbus_code = 16'hc001;
      CBUS_CECC_CORE0: cbus_code = 16'hc002;
      CBUS_CECC_CORE1: cbus_code = 16'hc004;
      CBUS_UECC_BUS: cbus_code = 16'he001;
      CBUS_UECC_CORE0: cbus_code = 16'he002;
      CBUS_UECC_CORE1: cbus_code = 16'he004;
      default: cbus_code = 16'h0000;
    endcase
  endfunction : cbus_code

  localparam logic [15:0] CBUS_RESERVED_CODE = 16'h0000;

  // ----------------------------------------------------------------
  // logged type and register port
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LOG_NONE, LOG_TYPE_A, LOG_TYPE_B, LOG_TYPE_C} log_kind_type;

  localparam logic [7:0] STATUS_LO_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_HI_OFFSET = 8'h04;
  localparam logic [7:0] CONTROL_OFFSET = 8'h08;
  localparam logic [7:0] DROPPED_OFFSET = 8'h0c;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam logic [7:0] DROP_MAX = 8'hff;

  typedef struct packed {
    logic fire;
    logic [LLC_WAYS-1:0] corr_ways;
    logic [LLC_WAYS-1:0] uncorr_ways;
    logic [LLC_WAYS-1:0] hit_ways;
  } llc_report_type;

  typedef struct packed {
    logic fire;
    logic [BUS_EVENTS-1:0] events;
    logic ecc_uncorr;
  } bus_report_type;

  typedef struct packed {
    logic fire;
    cbus_kind_type kind;
  } cbus_report_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_type;

endpackage : mc_code_pkg

// file: llc_code_encoder.sv
`timescale 1ns/10ps
`default_nettype none
module llc_code_encoder #(
  parameter int WAYS = mc_code_pkg::LLC_WAYS
) (
  input wire logic [WAYS-1:0] corr_ways,
  input wire logic [WAYS-1:0] uncorr_ways,
  input wire logic [WAYS-1:0] hit_ways,
  output logic [2:0] code,
  output logic uncorr
);

  function automatic logic several(input logic [WAYS-1:0] v);
    several = |(v & (v - WAYS'(1)));
  endfunction : several

  // the mixed case outranks the rest; more ways outrank one way
  always_comb begin
    uncorr = |uncorr_ways;
    // (RULE5) corr and uncorr together
    if ((|corr_ways) && (|uncorr_ways)) begin
      code = mc_code_pkg::LLC_MIXED;
    // (RULE3) several ways first
    end else if (several(uncorr_ways)) begin
      code = mc_code_pkg::LLC_MULTI_UNCORR;
    end else if (several(corr_ways)) begin
      code = mc_code_pkg::LLC_MULTI_CORR;
    end else if (several(hit_ways)) begin
      code = mc_code_pkg::LLC_MULTI_HIT;
    // (RULE4) exactly one way
    end else if (|uncorr_ways) begin
      code = mc_code_pkg::LLC_ONE_UNCORR;
    end else if (|corr_ways) begin
      code = mc_code_pkg::LLC_ONE_CORR;
    end else begin
      code = mc_code_pkg::LLC_NO_ERROR;
    end
  end

endmodule : llc_code_encoder
`default_nettype wire

// file: mc_bank4_error_code_encoder.sv
// Functional notes
// (RULE1) model code sits in status bits 31:16
// (RULE2) type A cache code in 18:16, 000/100 none
// (RULE3) several ways: 001 corr, 010 uncorr, 011 hit
// (RULE4) one way: 101 corr, 110 uncorr
// (RULE5) corr and uncorr together give 111
// (RULE6) type A: 20:19 zero, 31:21 fixed pattern
// (RULE7) type B bit 16: bus request parity
// (RULE8) bits 17/18: address parity core0/core1
// (RULE9) bit 20: bus response parity
// (RULE10) bit 21: inbound bus data parity
// (RULE11) bits 22/23: data parity core0/core1
// (RULE12) bit 24: enhanced defer parity
// (RULE13) bit 25: inbound data ecc, either class
// (RULE14) bits 26/27: data/request strobe glitch
// (RULE15) type B sets exactly one bit; reserved zero
// (RULE16) type B uncorrected except inbound ecc
// (RULE17) type C codes 0001-0004 core errors
// (RULE18) type C codes 0005-0007 bus errors
// (RULE19) type C 0008 arbitration, 0009 queue
// (RULE20) type C 0100, 0200/0300, 0400
// (RULE21) type C correctable ecc C001/C002/C004
// (RULE22) type C uncorrectable ecc E001/E002/E004
// (RULE23) bit 61 set when error uncorrected
// (RULE24) whole entry written in one cycle
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module mc_bank4_error_code_encoder #(
  parameter int WAYS = mc_code_pkg::LLC_WAYS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire mc_code_pkg::llc_report_type llc_report,
  input wire mc_code_pkg::bus_report_type bus_report,
  input wire mc_code_pkg::cbus_report_type cbus_report,
  input wire mc_code_pkg::reg_req_type reg_req,
  output logic [31:0] rd_data,
  output logic [63:0] bank_four_error_status,
  output logic uncorrected_flag
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // type A encoding
  // ----------------------------------------------------------------
  logic [2:0] llc_code;
  logic llc_uncorr;

  llc_code_encoder #(
    .WAYS(WAYS)
  ) u_llc_code (
    .corr_ways(llc_report.corr_ways),
    .uncorr_ways(llc_report.uncorr_ways),
    .hit_ways(llc_report.hit_ways),
    .code(llc_code),
    .uncorr(llc_uncorr)
  );

  // ----------------------------------------------------------------
  // type B and type C encoding
  // ----------------------------------------------------------------
  logic [15:0] bus_code;
  logic bus_uncorr;
  logic bus_any;
  logic [15:0] cbus_msc;
  logic cbus_known;
  logic cbus_uncorr;

  // (RULE15) lowest event index wins so only one bit is logged
  always_comb begin
    bus_code = 16'h0000;
    bus_uncorr = 1'b1;
    bus_any = 1'b0;
    for (int i = mc_code_pkg::BUS_EVENTS - 1; i >= 0; i--) begin
      if (bus_report.events[i]) begin
        bus_any = 1'b1;
        // (RULE8) address parity per core
        // (RULE9) response parity bit
        // (RULE10) inbound data parity bit
        // (RULE11) data parity per core
        // (RULE12) enhanced defer parity bit
        // (RULE14) strobe glitch bits
        // (RULE7) one bit per bus event
        bus_code = 16'h0001 << mc_code_pkg::bus_bit_pos(i);
        // (RULE13) inbound ecc keeps its class
        // (RULE16) only the inbound ecc event may be corrected
        bus_uncorr = (i == mc_code_pkg::BUS_ECC_INDEX) ? bus_report.ecc_uncorr : 1'b1;
      end
    end
  end

  // (RULE17) type C code table lookup
  always_comb begin
    // (RULE18) bus-side codes 0005-0007
    // (RULE19) arbitration and queue codes
    // (RULE20) thermal, timeout, queue-full codes
    cbus_msc = mc_code_pkg::cbus_code(cbus_report.kind);
    // (RULE22) reserved encodings are never logged
    cbus_known = (cbus_msc != mc_code_pkg::CBUS_RESERVED_CODE);
    // (RULE21) correctable ecc codes are the only corrected ones
    cbus_uncorr = (cbus_msc[15:12] != mc_code_pkg::CBUS_CORR_NIBBLE);
  end

  // ----------------------------------------------------------------
  // next entry
  // ----------------------------------------------------------------
  logic [63:0] status_ff;
  mc_code_pkg::log_kind_type logged_ff;
  logic enable_ff;
  logic [7:0] dropped_ff;
  logic [63:0] nxt_entry;
  mc_code_pkg::log_kind_type nxt_kind;
  logic nxt_uncorr;
  logic want_log;
  logic accept;
  logic clear_req;

  always_comb begin
    nxt_entry = 64'h0;
    nxt_kind = mc_code_pkg::LOG_NONE;
    nxt_uncorr = 1'b0;
    if (llc_report.fire) begin
      nxt_kind = mc_code_pkg::LOG_TYPE_A;
      nxt_uncorr = llc_uncorr;
      nxt_entry[15:0] = mc_code_pkg::TYPE_A_ERR_CODE;
      // (RULE2) cache sub-code in the low three bits
      nxt_entry[mc_code_pkg::MSC_LSB +: 3] = llc_code;
      // (RULE6) reserved pair and fixed pattern
      nxt_entry[20:19] = mc_code_pkg::LLC_RESERVED_BITS;
      nxt_entry[31:21] = mc_code_pkg::LLC_FIXED_PATTERN;
    end else if (bus_report.fire && bus_any) begin
      nxt_kind = mc_code_pkg::LOG_TYPE_B;
      nxt_uncorr = bus_uncorr;
      nxt_entry[15:0] = mc_code_pkg::TYPE_B_ERR_CODE;
      // (RULE1) model code field
      nxt_entry[mc_code_pkg::MSC_MSB:mc_code_pkg::MSC_LSB] = bus_code;
    end else if (cbus_report.fire && cbus_known) begin
      nxt_kind = mc_code_pkg::LOG_TYPE_C;
      nxt_uncorr = cbus_uncorr;
      nxt_entry[15:0] = mc_code_pkg::TYPE_C_ERR_CODE;
      nxt_entry[mc_code_pkg::MSC_MSB:mc_code_pkg::MSC_LSB] = cbus_msc;
    end
    // (RULE23) uncorrected flag travels with the entry
    nxt_entry[mc_code_pkg::UNCORR_BIT] = nxt_uncorr;
    nxt_entry[mc_code_pkg::VAL_BIT] = 1'b1;
  end

  // an uncorrected error may replace a corrected one, never the reverse
  assign want_log = enable_ff && (nxt_kind != mc_code_pkg::LOG_NONE);
  assign clear_req = reg_req.wr && (reg_req.addr == mc_code_pkg::CONTROL_OFFSET)
                     && reg_req.wdata[mc_code_pkg::CTRL_CLEAR_BIT];
  assign accept = want_log && (!status_ff[mc_code_pkg::VAL_BIT] || clear_req
                  || (nxt_uncorr && !status_ff[mc_code_pkg::UNCORR_BIT]));

  // ----------------------------------------------------------------
  // status entry
  // ----------------------------------------------------------------
  // (RULE24) entry and code land together; a new error beats a clear
  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      status_ff <= 64'h0;
      logged_ff <= mc_code_pkg::LOG_NONE;
    end else if (accept) begin
      status_ff <= nxt_entry;
      status_ff[mc_code_pkg::OVER_BIT] <= status_ff[mc_code_pkg::VAL_BIT] && !clear_req;
      logged_ff <= nxt_kind;
    end else if (want_log) begin
      status_ff[mc_code_pkg::OVER_BIT] <= 1'b1;
    end else if (clear_req) begin
      status_ff <= 64'h0;
      logged_ff <= mc_code_pkg::LOG_NONE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      dropped_ff <= 8'h00;
    end else if (want_log && !accept && dropped_ff != mc_code_pkg::DROP_MAX) begin
      dropped_ff <= dropped_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      enable_ff <= mc_code_pkg::CTRL_ENABLE_RESET;
    end else if (reg_req.wr && reg_req.addr == mc_code_pkg::CONTROL_OFFSET) begin
      enable_ff <= reg_req.wdata[mc_code_pkg::CTRL_ENABLE_BIT];
    end
  end

  assign bank_four_error_status = status_ff;
  assign uncorrected_flag = status_ff[mc_code_pkg::UNCORR_BIT];

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  logic [31:0] rd_data_ff;

  // data stands only in the cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_sys or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rd_data_ff <= 32'h0;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        mc_code_pkg::STATUS_LO_OFFSET: rd_data_ff <= status_ff[31:0];
        mc_code_pkg::STATUS_HI_OFFSET: rd_data_ff <= status_ff[63:32];
        mc_code_pkg::CONTROL_OFFSET: rd_data_ff <= {31'h0, enable_ff};
        mc_code_pkg::DROPPED_OFFSET: rd_data_ff <= {24'h0, dropped_ff};
        default: rd_data_ff <= 32'h0;
      endcase
    end else begin
      rd_data_ff <= 32'h0;
    end
  end

  assign rd_data = rd_data_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  fixed_pattern_a: // (RULE6)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    logged_ff == mc_code_pkg::LOG_TYPE_A |-> status_ff[31:19] == 13'h0400)
    else $error("type A upper bits wrong");

  llc_mixed_a: // (RULE5)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    accept && llc_report.fire && (|llc_report.corr_ways) && (|llc_report.uncorr_ways)
    |=> status_ff[18:16] == 3'h7 && status_ff[61])
    else $error("mixed ways not coded 111");

  llc_single_a: // (RULE4)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    accept && llc_report.fire && $onehot(llc_report.corr_ways) && llc_report.uncorr_ways == '0
    && llc_report.hit_ways == '0 |=> status_ff[18:16] == 3'h5 && !status_ff[61])
    else $error("single correctable way not coded 101");

  bus_onehot_a: // (RULE15)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    logged_ff == mc_code_pkg::LOG_TYPE_B |-> $onehot(status_ff[31:16])
    && status_ff[19] == 1'b0 && status_ff[31:28] == 4'h0)
    else $error("type B code not one defined bit");

  bus_uncorr_a: // (RULE16)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    logged_ff == mc_code_pkg::LOG_TYPE_B && !status_ff[25] |-> status_ff[61])
    else $error("non-ecc bus error logged corrected");

  bus_ecc_a: // (RULE13)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    accept && !llc_report.fire && bus_report.fire && bus_report.events == 11'h100
    |=> status_ff[31:16] == 16'h0200 && status_ff[61] == $past(bus_report.ecc_uncorr))
    else $error("inbound ecc bit or class wrong");

  cbus_class_a: // (RULE21)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    logged_ff == mc_code_pkg::LOG_TYPE_C |-> status_ff[61] == (status_ff[31:28] != 4'hc))
    else $error("type C class mismatch");

  log_atomic_a: // (RULE24)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    !accept && !clear_req |=> $stable(status_ff[61:0]))
    else $error("entry changed without a log");

  read_window_a:
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    !reg_req.rd |=> rd_data_ff == 32'h0)
    else $error("read data outside its cycle");

  llc_none_a: // (RULE2)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    accept && llc_report.fire && {llc_report.corr_ways, llc_report.uncorr_ways, llc_report.hit_ways} == '0
    |=> status_ff[18:16] == 3'h0 && !status_ff[61])
    else $error("quiet way report not coded 000");

  llc_multi_corr_a: // (RULE3)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    accept && llc_report.fire && !$onehot0(llc_report.corr_ways) && llc_report.uncorr_ways == '0
    |=> status_ff[18:16] == 3'h1 && !status_ff[61])
    else $error("several correctable ways not coded 001");

  llc_multi_uncorr_a: // (RULE3)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    accept && llc_report.fire && llc_report.corr_ways == '0 && !$onehot0(llc_report.uncorr_ways)
    |=> status_ff[18:16] == 3'h2 && status_ff[61])
    else $error("several uncorrectable ways not coded 010");

  llc_multi_hit_a: // (RULE3)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    accept && llc_report.fire && {llc_report.corr_ways, llc_report.uncorr_ways} == '0
    && !$onehot0(llc_report.hit_ways) |=> status_ff[18:16] == 3'h3 && !status_ff[61])
    else $error("several hit ways not coded 011");

  llc_one_uncorr_a: // (RULE4)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    accept && llc_report.fire && llc_report.corr_ways == '0 && $onehot(llc_report.uncorr_ways)
    && $onehot0(llc_report.hit_ways) |=> status_ff[18:16] == 3'h6 && status_ff[61])
    else $error("single uncorrectable way not coded 110");

  bus_addr_core1_a: // (RULE8)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    accept && !llc_report.fire && bus_report.fire && bus_report.events == 11'h004
    |=> status_ff[31:16] == 16'h0004)
    else $error("core 1 address parity not at bit 18");

  bus_response_a: // (RULE9)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    accept && !llc_report.fire && bus_report.fire && bus_report.events == 11'h008
    |=> status_ff[31:16] == 16'h0010)
    else $error("response parity not at bit 20");

  bus_inbound_parity_a: // (RULE10)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    accept && !llc_report.fire && bus_report.fire && bus_report.events == 11'h010
    |=> status_ff[31:16] == 16'h0020)
    else $error("inbound data parity not at bit 21");

  bus_data_core1_a: // (RULE11)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    accept && !llc_report.fire && bus_report.fire && bus_report.events == 11'h040
    |=> status_ff[31:16] == 16'h0080)
    else $error("core 1 data parity not at bit 23");

  bus_defer_a: // (RULE12)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    accept && !llc_report.fire && bus_report.fire && bus_report.events == 11'h080
    |=> status_ff[31:16] == 16'h0100)
    else $error("enhanced defer parity not at bit 24");

  bus_req_glitch_a: // (RULE14)
  assert property (@(posedge clk_sys) disable iff (!rst_sync_ff)
    accept && !llc_report.fire && bus_report.fire && bus_report.events == 11'h400
    |=> status_ff[31:16] == 16'h0800)
    else $error("request strobe glitch not at bit 27");

endmodule : mc_bank4_error_code_encoder
`default_nettype wire

// file: mc_bank4_error_code_encoder_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin errors++; $display("MISMATCH at %0t: got %h expected %h", $time, (got), (exp)); end end
module mc_bank4_error_code_encoder_bench;
  logic clk_sys;
  logic rst_n;
  mc_code_pkg::llc_report_type llc_report;
  mc_code_pkg::bus_report_type bus_report;
  mc_code_pkg::cbus_report_type cbus_report;
  mc_code_pkg::reg_req_type reg_req;
  logic [31:0] rd_data;
  logic [63:0] bank_four_error_status;
  logic uncorrected_flag;
  int errors;
  int compares;
  // expected codes kept apart from the package so a wrong table there shows up
  logic [15:0] bus_msc [11] = '{16'h0001, 16'h0002, 16'h0004, 16'h0010, 16'h0020, 16'h0040, 16'h0080,
                                16'h0100, 16'h0200, 16'h0400, 16'h0800};
  logic [15:0] cbus_msc [19] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007,
                                16'h0008, 16'h0009, 16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'hc001,
                                16'hc002, 16'hc004, 16'he001, 16'he002, 16'he004};

  mc_bank4_error_code_encoder #(.WAYS(mc_code_pkg::LLC_WAYS)) u_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .llc_report(llc_report),
    .bus_report(bus_report),
    .cbus_report(cbus_report),
    .reg_req(reg_req),
    .rd_data(rd_data),
    .bank_four_error_status(bank_four_error_status),
    .uncorrected_flag(uncorrected_flag)
  );

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // bus and report drivers
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask : reg_wr

  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] addr, output logic [31:0] data);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h0};
    @(posedge clk_sys);
    reg_req <= '0;
    #1;
    data = rd_data;
  endtask : reg_rd

  function automatic mc_code_pkg::llc_report_type mk_a(input logic [7:0] c, input logic [7:0] u,
                                                        input logic [7:0] h);
    mk_a = '{fire: 1'b1, corr_ways: c, uncorr_ways: u, hit_ways: h};
  endfunction : mk_a

  function automatic mc_code_pkg::bus_report_type mk_b(input logic [10:0] ev, input logic eu);
    mk_b = '{fire: 1'b1, events: ev, ecc_uncorr: eu};
  endfunction : mk_b

  function automatic mc_code_pkg::cbus_report_type mk_c(input int k);
    mk_c = '{fire: 1'b1, kind: mc_code_pkg::cbus_kind_type'(k)};
  endfunction : mk_c

  // entry is visible one cycle after the report edge
  task automatic send(input mc_code_pkg::llc_report_type a, input mc_code_pkg::bus_report_type b,
                      input mc_code_pkg::cbus_report_type c);
    @(posedge clk_sys);
    llc_report <= a;
    bus_report <= b;
    cbus_report <= c;
    @(posedge clk_sys);
    llc_report <= '0;
    bus_report <= '0;
    cbus_report <= '0;
    #1;
  endtask : send

  task automatic clear_entry();
    reg_wr(mc_code_pkg::CONTROL_OFFSET, 32'h0000_0003);
  endtask : clear_entry

  task automatic expect_entry(input logic [15:0] tcode, input logic [15:0] msc, input logic uc);
    `CHK(bank_four_error_status[15:0], tcode)
    `CHK(bank_four_error_status[31:16], msc)
    `CHK(bank_four_error_status[61], uc)
    `CHK(uncorrected_flag, uc)
    `CHK(bank_four_error_status[63], 1'b1)
  endtask : expect_entry

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    `CHK(bank_four_error_status, 64'h0)
    reg_rd(mc_code_pkg::CONTROL_OFFSET, d);
    `CHK(d[0], 1'b1)
    reg_rd(mc_code_pkg::DROPPED_OFFSET, d);
    `CHK(d, 32'h0)
    reg_rd(8'h10, d);
    `CHK(d, 32'h0)
  endtask : t_reset

  task automatic t_type_a();
    logic [7:0] cw [7] = '{8'h03, 8'h00, 8'h00, 8'h10, 8'h00, 8'h01, 8'h00};
    logic [7:0] uw [7] = '{8'h00, 8'h81, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00};
    logic [7:0] hw [7] = '{8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [2:0] code [7] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7, 3'h0};
    for (int i = 0; i < 7; i++) begin
      send(mk_a(cw[i], uw[i], hw[i]), '0, '0);
      expect_entry(16'h010b, {13'h0400, code[i]}, |uw[i]);
      clear_entry();
    end
  endtask : t_type_a

  task automatic t_type_b();
    for (int i = 0; i < 11; i++) begin
      send('0, mk_b(11'h001 << i, 1'b0), '0);
      expect_entry(16'h0e0f, bus_msc[i], i != 8);
      clear_entry();
    end
    send('0, mk_b(11'h100, 1'b1), '0);
    expect_entry(16'h0e0f, 16'h0200, 1'b1);
    clear_entry();
    // several detectors at once still leave a single bit
    send('0, mk_b(11'h0a0, 1'b0), '0);
    expect_entry(16'h0e0f, 16'h0040, 1'b1);
    clear_entry();
    send('0, mk_b(11'h000, 1'b0), '0);
    `CHK(bank_four_error_status[63], 1'b0)
  endtask : t_type_b

  task automatic t_type_c();
    for (int i = 0; i < 19; i++) begin
      send('0, '0, mk_c(i));
      expect_entry(16'h0400, cbus_msc[i], !(i inside {13, 14, 15}));
      clear_entry();
    end
    send('0, '0, mk_c(19));
    `CHK(bank_four_error_status[63], 1'b0)
  endtask : t_type_c

  // corrected entry upgraded back to back, then a further error is refused
  task automatic t_overwrite();
    logic [31:0] d;
    @(posedge clk_sys);
    cbus_report <= mk_c(14);
    @(posedge clk_sys);
    cbus_report <= '0;
    bus_report <= mk_b(11'h001, 1'b0);
    @(posedge clk_sys);
    bus_report <= '0;
    #1;
    expect_entry(16'h0e0f, 16'h0001, 1'b1);
    send('0, '0, mk_c(0));
    expect_entry(16'h0e0f, 16'h0001, 1'b1);
    `CHK(bank_four_error_status[62], 1'b1)
    reg_rd(mc_code_pkg::DROPPED_OFFSET, d);
    `CHK(d, 32'h1)
    reg_rd(mc_code_pkg::STATUS_LO_OFFSET, d);
    `CHK(d, 32'h0001_0e0f)
    reg_rd(mc_code_pkg::STATUS_HI_OFFSET, d);
    `CHK(d, 32'he000_0000)
    @(posedge clk_sys);
    #1;
    `CHK(rd_data, 32'h0)
    clear_entry();
  endtask : t_overwrite

  task automatic t_priority_enable();
    send(mk_a(8'h10, 8'h00, 8'h00), mk_b(11'h002, 1'b0), mk_c(16));
    expect_entry(16'h010b, 16'h2005, 1'b0);
    clear_entry();
    reg_wr(mc_code_pkg::CONTROL_OFFSET, 32'h0);
    send('0, '0, mk_c(16));
    `CHK(bank_four_error_status[63], 1'b0)
    reg_wr(mc_code_pkg::CONTROL_OFFSET, 32'h1);
    send('0, '0, mk_c(16));
    expect_entry(16'h0400, 16'he001, 1'b1);
  endtask : t_priority_enable

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    errors = 0;
    compares = 0;
    rst_n = 1'b0;
    llc_report = '0;
    bus_report = '0;
    cbus_report = '0;
    reg_req = '0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_type_a();
    t_type_b();
    t_type_c();
    t_overwrite();
    t_priority_enable();
    wrap_up();
  end

  // the sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    wrap_up();
  end
endmodule : mc_bank4_error_code_encoder_bench
`undef CHK
`default_nettype wire
